// ---- core/flpc_pkg.sv ----
// package for the fifo level and power control register bank
package flpc_pkg;
	// register byte offsets
	localparam logic [7:0] RX_LEVELS_OFS = 8'h7C;
	localparam logic [7:0] TX_LEVELS_OFS = 8'h80;
	localparam logic [7:0] PWR_CTRL_OFS = 8'h84;
	// byte-test register offset, a write wakes the device
	localparam logic [7:0] BYTE_TEST_OFS = 8'h64;
	// power control field positions
	localparam int PSEL_LO = 12;
	localparam int PHYRST_BIT = 10;
	localparam int WFEN_BIT = 9;
	localparam int EDEN_BIT = 8;
	localparam int DRVTYPE_BIT = 6;
	localparam int WUPS_LO = 4;
	localparam int PULSE_BIT = 3;
	localparam int POL_BIT = 2;
	localparam int PINEN_BIT = 1;
	localparam int READY_BIT = 0;
	// reset values and power state codes
	localparam logic [15:0] TX_FREE_RESET = 16'h1200;
	localparam logic [1:0] PSEL_RESET = 2'h0;
	localparam logic [1:0] PSEL_NORMAL = 2'h0;
	localparam logic [1:0] PSEL_WAKEFRAME = 2'h1;
	localparam logic [1:0] PSEL_ENERGY = 2'h2;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int PHY_RESET_REQUEST_US = 100;
	localparam int PHY_RESET_REQUEST_CYC = PHY_RESET_REQUEST_US * CLK_MHZ;
	localparam int PULSE_MS = 50;
	localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
	localparam int WAKE_SETTLE_CYC = 16;
	localparam int CNT_W = 23;

	// fifo level inputs from the datapath
	typedef struct packed {
		logic [7:0] rxStatusUsedDwords;
		logic [15:0] rxDataUsedBytes;
		logic [7:0] txStatusUsedDwords;
		logic [15:0] txDataFreeBytes;
	} flpc_levels_type;

	// wake pin as two signals; oe low means driving
	typedef struct packed {
		logic o;
		logic oeN;
	} flpc_pin_type;
endpackage : flpc_pkg

// ---- core/flpc_timer.sv ----
// one-shot down counter for long hold times
`timescale 1ns/1ps
module flpc_timer #(
	parameter int W = 23
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic busy
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
	} flpc_tmr_type;
	flpc_tmr_type st_q, st_d;

	// restart on start, otherwise count down to zero
	always_comb begin
		st_d = st_q;
		if (start) begin
			st_d.cnt = load;
			st_d.busy = 1'b1;
		end else if (st_q.busy) begin
			if (st_q.cnt <= W'(1)) begin
				st_d.busy = 1'b0;
				st_d.cnt = '0;
			end else begin
				st_d.cnt = st_q.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign busy = st_q.busy;
endmodule : flpc_timer

// ---- core/flpc_regs.sv ----
// fifo level and power management register bank on avalon-mm
// Contract
// - rx level register bits 23-16 show rx status fifo dwords, reset zero.
// - bits 15-0 show rx data fifo used bytes, dword rounded per frame.
// - tx level register bits 23-16 show tx status fifo dwords, reset zero.
// - tx level bits 15-0 show tx data free bytes, reset 1200h.
// - power control register stays readable in every power-saving state.
// - a read must occur after reset or wake before writes take effect.
// - bits 13-12 select power state, self clearing, reset 00b.
// - any write to the byte-test register wakes a sleeping device.
// - bit 10 resets the phy for at least 100us, then self-clears.
// - writes to bit 10 are ignored while it is still set.
// - bit 9 lets wake frames drive the pin and the wake interrupt.
// - bit 8 lets energy detect drive the pin and the wake interrupt.
// - bit 6 clear gives open-drain active-low pin; set gives push-pull.
// - bit 0 reads ready when awake; other addresses invalid until set.
// - pulse style asserts the pin 50ms per event, else continuously.
// - bit 2 sets push-pull polarity: one high, zero low.
// - bit 1 gates only the external pin, never the wake interrupt.
`timescale 1ns/1ps
module flpc_regs #(
	parameter int PhyRstCyc = flpc_pkg::PHY_RESET_REQUEST_CYC,
	parameter int PulseCyc = flpc_pkg::PULSE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire flpc_pkg::flpc_levels_type levels,
	input wire logic wakeFrameEvent,
	input wire logic energyDetectEvent,
	output logic [1:0] powerState,
	output logic phyReset,
	output logic wakeInterrupt,
	output flpc_pkg::flpc_pin_type wakeEventOut
);
	import flpc_pkg::*;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_DONE = 2'h1
	} flpc_bus_type;

	typedef struct packed {
		flpc_bus_type bus;
		logic waitReq;
		logic [31:0] rdata;
		logic readSeen;
		logic [1:0] psel;
		logic asleep;
		logic ready;
		logic [4:0] settle;
		logic phyRst;
		logic wfEn;
		logic edEn;
		logic drvType;
		logic [1:0] wups;
		logic pulse;
		logic pol;
		logic pinEn;
		logic pinO;
		logic pinOeN;
		logic irq;
	} flpc_state_type;

	flpc_state_type st_q, st_d;
	logic phyBusy, pulseBusy, phyStart, pulseStart;
	logic [CNT_W-1:0] phyLoad, pulseLoad;
	logic accept, wrOk, pinActive, pinLevel, newEvent;

	assign phyLoad = CNT_W'(PhyRstCyc);
	assign pulseLoad = CNT_W'(PulseCyc);

	// phy reset hold timer
	flpc_timer #(.W(CNT_W)) phyTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(phyStart),
		.load(phyLoad),
		.busy(phyBusy)
	);

	// wake pin pulse timer
	flpc_timer #(.W(CNT_W)) pulseTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(pulseStart),
		.load(pulseLoad),
		.busy(pulseBusy)
	);

	// request accepted on the first cycle, answered the next
	assign accept = (read | write) && st_q.bus == BUS_IDLE;
	assign wrOk = accept && write && st_q.readSeen;
	assign newEvent = (wakeFrameEvent && st_q.wfEn)
		|| (energyDetectEvent && st_q.edEn);
	assign phyStart = wrOk && address == PWR_CTRL_OFS && byteenable[1]
		&& writedata[PHYRST_BIT] && !st_q.phyRst
		&& st_q.ready;
	assign pulseStart = newEvent && st_q.pulse;
	// static style holds while status remains, pulse style while timing
	assign pinActive = st_q.pinEn
		&& (st_q.pulse ? pulseBusy : (st_q.wups != 2'h0));

	always_comb begin
		pinLevel = 1'b1;
		if (st_q.drvType) begin
			pinLevel = st_q.pol ? pinActive : !pinActive;
		end else begin
			pinLevel = !pinActive;
		end
	end

	// main next-state logic
	always_comb begin
		st_d = st_q;
		// one-cycle answer, then back to idle
		case (st_q.bus)
			BUS_IDLE: begin
				if (accept) begin
					st_d.bus = BUS_DONE;
				end
			end
			BUS_DONE: begin
				st_d.bus = BUS_IDLE;
			end
			default: begin
				st_d.bus = BUS_IDLE;
			end
		endcase
		// flopped copy, so waitrequest leaves a register directly
		st_d.waitReq = st_d.bus != BUS_DONE;
		if (accept && read) begin
			st_d.readSeen = 1'b1;
			case (address)
				RX_LEVELS_OFS: st_d.rdata = {8'h00,
					levels.rxStatusUsedDwords, levels.rxDataUsedBytes};
				TX_LEVELS_OFS: st_d.rdata = {8'h00,
					levels.txStatusUsedDwords, levels.txDataFreeBytes};
				PWR_CTRL_OFS: st_d.rdata = {18'h00000, st_q.psel, 1'b0,
					st_q.phyRst, st_q.wfEn, st_q.edEn, 1'b0, st_q.drvType,
					st_q.wups, st_q.pulse, st_q.pol, st_q.pinEn,
					st_q.ready};
				default: st_d.rdata = 32'h00000000;
			endcase
		end
		// register writes, low then high byte lanes
		if (wrOk && address == PWR_CTRL_OFS && st_q.ready) begin
			if (byteenable[0]) begin
				st_d.drvType = writedata[DRVTYPE_BIT];
				st_d.pulse = writedata[PULSE_BIT];
				st_d.pol = writedata[POL_BIT];
				st_d.pinEn = writedata[PINEN_BIT];
				// clear status by writing one
				st_d.wups = st_q.wups & ~writedata[WUPS_LO +: 2];
			end
			if (byteenable[1]) begin
				st_d.wfEn = writedata[WFEN_BIT];
				st_d.edEn = writedata[EDEN_BIT];
				if (writedata[PSEL_LO +: 2] == PSEL_WAKEFRAME
					|| writedata[PSEL_LO +: 2] == PSEL_ENERGY) begin
					st_d.psel = writedata[PSEL_LO +: 2];
					st_d.asleep = 1'b1;
					st_d.ready = 1'b0;
					st_d.readSeen = 1'b0;
				end
			end
		end
		if (phyStart) begin
			st_d.phyRst = 1'b1;
		end else if (st_q.phyRst && !phyBusy) begin
			st_d.phyRst = 1'b0;
		end
		// byte-test write wakes, independent of read gating
		if (accept && write && address == BYTE_TEST_OFS && st_q.asleep) begin
			st_d.asleep = 1'b0;
			st_d.settle = 5'(WAKE_SETTLE_CYC);
			st_d.readSeen = 1'b0;
		end
		// mode field clears once awake and settled
		if (!st_q.asleep && !st_q.ready) begin
			if (st_q.settle == 5'h00) begin
				st_d.ready = 1'b1;
				st_d.psel = PSEL_NORMAL;
			end else begin
				st_d.settle = st_q.settle - 5'h01;
			end
		end
		// event status, set wins over clear
		if (wakeFrameEvent && st_q.wfEn) begin
			st_d.wups[1] = 1'b1;
		end
		if (energyDetectEvent && st_q.edEn) begin
			st_d.wups[0] = 1'b1;
		end
		st_d.irq = st_d.wups != 2'h0;
		st_d.pinO = pinLevel;
		st_d.pinOeN = st_q.drvType ? 1'b0 : pinLevel;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.psel <= PSEL_RESET;
			st_q.settle <= 5'(WAKE_SETTLE_CYC);
			st_q.pinO <= 1'b1;
			st_q.pinOeN <= 1'b1;
			st_q.waitReq <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	assign readdata = st_q.rdata;
	assign waitrequest = st_q.waitReq;
	assign powerState = st_q.psel;
	assign phyReset = st_q.phyRst;
	assign wakeInterrupt = st_q.irq;
	assign wakeEventOut.o = st_q.pinO;
	assign wakeEventOut.oeN = st_q.pinOeN;

	sequence phyReq_s;
		phyStart;
	endsequence

	sequence pulseReq_s;
		pulseStart;
	endsequence

	// hold high for at least eight cycles after the request
	phy_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		phyReq_s |=> phyReset [*8]) else $error("phy reset dropped early");
	// set bit stays set on rewrite
	phy_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
		phyReset && phyBusy |=> phyReset) else $error("phy reset lost");
	write_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		!st_q.readSeen |-> !wrOk) else $error("write before read");
	irq_status_a: assert property (@(posedge sys_clk) disable iff (rst)
		st_q.wups != 2'h0 |-> wakeInterrupt) else $error("irq missing");
	od_low_a: assert property (@(posedge sys_clk) disable iff (rst)
		!wakeEventOut.oeN && !$past(st_q.drvType) |-> !wakeEventOut.o)
		else $error("open drain drove high");
	wf_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
		wakeFrameEvent && st_q.wfEn |=> wakeInterrupt)
		else $error("wake frame lost");
	ed_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
		energyDetectEvent && st_q.edEn |=> wakeInterrupt)
		else $error("energy event lost");
	read_ans_a: assert property (@(posedge sys_clk) disable iff (rst)
		accept |=> !waitrequest ##1 waitrequest) else $error("no answer");
	mode_ok_a: assert property (@(posedge sys_clk) disable iff (rst)
		powerState != 2'h3) else $error("reserved power state");
	rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		!waitrequest |-> readdata[31:24] == 8'h00) else $error("rsvd set");
	// pulse timer runs after an event
	pulse_len_a: assert property (@(posedge sys_clk) disable iff (rst)
		pulseReq_s |=> pulseBusy [*8]) else $error("pulse cut short");
	pin_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(st_q.pinEn) && !$past(st_q.drvType) |-> wakeEventOut.oeN)
		else $error("disabled pin driven");
	// byte-test write wakes, mode clears after settling
	wake_up_a: assert property (@(posedge sys_clk) disable iff (rst)
		accept && write && address == BYTE_TEST_OFS && st_q.asleep
		|=> !st_q.asleep ##17 powerState == 2'h0) else $error("no wake");
endmodule : flpc_regs

// ---- sim/flpc_host_model.sv ----
// host bus model: one avalon-mm transfer per request pulse
`timescale 1ns/1ps
module flpc_host_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reqGo,
	input wire logic reqWr,
	input wire logic [7:0] reqAddr,
	input wire logic [31:0] reqData,
	output logic reqDone,
	output logic [31:0] respData,
	output logic [7:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	logic busy;

	// request held until waitrequest low, then released
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			read <= 1'b0;
			write <= 1'b0;
			reqDone <= 1'b0;
			address <= 8'h00;
			writedata <= 32'h0;
			byteenable <= 4'hF;
			respData <= 32'h0;
		end else begin
			reqDone <= 1'b0;
			if (busy && !waitrequest) begin
				busy <= 1'b0;
				read <= 1'b0;
				write <= 1'b0;
				respData <= readdata;
				reqDone <= 1'b1;
				// released data lines show junk, not the last value
				writedata <= ~writedata;
				address <= ~address;
			end else if (!busy && reqGo) begin
				busy <= 1'b1;
				read <= !reqWr;
				write <= reqWr;
				address <= reqAddr;
				writedata <= reqData;
			end
		end
	end
endmodule : flpc_host_model

// ---- sim/tb_fifo_level_and_power_control.sv ----
// self-checking bench for the fifo level and power control bank
`timescale 1ns/1ps
module tb_fifo_level_and_power_control;
	import flpc_pkg::*;
	logic sys_clk, rst, reqGo, reqWr, reqDone, wfEv, edEv, read, write;
	logic waitrequest, phyReset, wakeInterrupt;
	logic [7:0] address, reqAddr;
	logic [31:0] writedata, readdata, reqData, respData, rd;
	logic [3:0] byteenable;
	logic [1:0] powerState;
	flpc_levels_type lv;
	flpc_pin_type pin;
	int err_total, checks, cyc, t0;

	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	flpc_regs #(.PhyRstCyc(60), .PulseCyc(40)) uut (.sys_clk(sys_clk),
		.rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .levels(lv), .wakeFrameEvent(wfEv),
		.energyDetectEvent(edEv), .powerState(powerState),
		.phyReset(phyReset), .wakeInterrupt(wakeInterrupt),
		.wakeEventOut(pin));
	flpc_host_model host (.sys_clk(sys_clk), .rst(rst), .reqGo(reqGo),
		.reqWr(reqWr), .reqAddr(reqAddr), .reqData(reqData),
		.reqDone(reqDone), .respData(respData), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk

	// one transfer; waits for the model, the hang guard bounds the wait
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		reqGo <= 1'b1;
		reqWr <= wr;
		reqAddr <= a;
		reqData <= d;
		@(posedge sys_clk);
		reqGo <= 1'b0;
		while (reqDone !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		rd = respData;
	endtask : acc

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdc

	// one-cycle wake event, frame or energy
	task automatic ev(input logic wf);
		@(posedge sys_clk);
		wfEv <= wf;
		edEv <= !wf;
		@(posedge sys_clk);
		wfEv <= 1'b0;
		edEv <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : ev

	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			$display("FAIL run_length expected below %0d seen %0d", 4000, cyc);
			err_total++;
			print_verdict();
		end
	end

	// host pushes nothing, so the tx free count stays put
	initial begin
		rst = 1'b1;
		{reqGo, reqWr, wfEv, edEv, reqAddr, reqData} = '0;
		lv = '{8'h05, 16'h0104, 8'h03, TX_FREE_RESET};
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (20) @(posedge sys_clk);
		acc(1'b1, PWR_CTRL_OFS, 32'h2);
		rdc("pmctl", PWR_CTRL_OFS, 32'h1);
		rdc("rxlev", RX_LEVELS_OFS, 32'h0005_0104);
		chk("rxdata", 32'h0104, {16'h0, rd[15:0]});
		rdc("txlev", TX_LEVELS_OFS, 32'h0003_1200);
		chk("txfree", 32'h1200, {16'h0, rd[15:0]});
		rdc("unmapped", 8'h10, 32'h0);
		acc(1'b1, PWR_CTRL_OFS, 32'hFFFF_CBC7);
		rdc("pmctl", PWR_CTRL_OFS, 32'h347);
		ev(1'b0);
		chk("irq", 32'h1, {31'h0, wakeInterrupt});
		chk("pinhigh", 32'h2, {30'h0, pin});
		rdc("status", PWR_CTRL_OFS, 32'h357);
		acc(1'b1, PWR_CTRL_OFS, 32'h236);
		ev(1'b1);
		chk("irq", 32'h1, {31'h0, wakeInterrupt});
		chk("pinod", 32'h0, {30'h0, pin});
		acc(1'b1, PWR_CTRL_OFS, 32'h130);
		ev(1'b0);
		chk("irq", 32'h1, {31'h0, wakeInterrupt});
		chk("pinoff", 32'h1, {31'h0, pin.oeN});
		acc(1'b1, PWR_CTRL_OFS, 32'h17E);
		ev(1'b0);
		chk("pulse", 32'h2, {30'h0, pin});
		repeat (45) @(posedge sys_clk);
		#1;
		chk("pulseend", 32'h0, {30'h0, pin});
		acc(1'b1, PWR_CTRL_OFS, 32'h430);
		t0 = cyc;
		// a second set while held must not restart the hold
		acc(1'b1, PWR_CTRL_OFS, 32'h400);
		rdc("phyrst", PWR_CTRL_OFS, 32'h401);
		chk("phyline", 32'h1, {31'h0, phyReset});
		while (phyReset === 1'b1 && cyc < t0 + 200) begin
			@(posedge sys_clk);
			#1;
		end
		// held for the 60-cycle sim setting, not stretched
		chk("phyhold", 32'h1, {31'h0, (cyc - t0) >= 59
			&& (cyc - t0) <= 61});
		rdc("phyclr", PWR_CTRL_OFS, 32'h1);
		for (int m = 1; m < 3; m++) begin
			acc(1'b1, PWR_CTRL_OFS, 32'(m) << PSEL_LO);
			repeat (2) @(posedge sys_clk);
			#1;
			chk("pstate", 32'(m), {30'h0, powerState});
			acc(1'b0, PWR_CTRL_OFS, 32'h0);
			chk("asleep", 32'h0, {31'h0, rd[READY_BIT]});
			acc(1'b1, BYTE_TEST_OFS, 32'h0);
			repeat (25) @(posedge sys_clk);
			#1;
			chk("woken", 32'h0, {30'h0, powerState});
			rdc("ready", PWR_CTRL_OFS, 32'h1);
		end
		print_verdict();
	end
endmodule : tb_fifo_level_and_power_control
